// >>> design/fwf_filter.sv
`timescale 1ns/1ps
`default_nettype none
`include "fwf_regs.svh"

module fwf_filter #(
  parameter int WIN_W = 15,
  parameter int T_MAX_CYC = `FWF_TMAX_NS / `FWF_CLK_PERIOD_NS
) (
  input wire logic ref_clk_i,                   // System clock, 100 MHz
  input wire logic rst_i,                       // Synchronous reset, active high
  input wire logic ce_i,                        // Clock enable, freezes state when low
  input wire logic [3:0] addr_i,                // Register byte address
  input wire logic [31:0] wdata_i,              // Register write data
  input wire logic wr_i,                        // Write strobe
  input wire logic rd_i,                        // Read strobe
  output logic [31:0] rdata_o,                  // Read data, cycle after strobe
  input wire logic sq_i,                        // Squared comparator signal
  input wire fwf_pkg::fwf_peak_type peak_i,     // Thermometer peak level
  input wire logic diag_i,                      // Diagnosis running
  output logic filt_o,                          // Filtered pulse to controller
  output fwf_pkg::fwf_step_type step_o,         // Hysteresis step to shaper
  output logic fb_o                             // Hysteresis feedback signal
);
  import fwf_pkg::*;

  // ----------------------------------------------------------------
  // Derived constants
  // ----------------------------------------------------------------
  localparam int PER_W = WIN_W + `FWF_PERIOD_SHIFT;
  // Least window rounds up to whole cycles
  localparam int T_MIN_CYC = (`FWF_TMIN_NS + `FWF_CLK_PERIOD_NS - 1) / `FWF_CLK_PERIOD_NS;
  localparam logic [WIN_W-1:0] WIN_MIN = WIN_W'(T_MIN_CYC);
  localparam logic [WIN_W-1:0] WIN_MAX = WIN_W'(T_MAX_CYC);
  localparam logic [PER_W-1:0] PER_SAT = {PER_W{1'b1}};

  // Refuse sizes the counters cannot hold, while elaborating
  if (T_MAX_CYC >= (1 << WIN_W) || T_MAX_CYC < T_MIN_CYC || WIN_W > 16) begin : g_bad_size
    $error("fwf_filter: window width cannot hold the window limits");
  end

  // ----------------------------------------------------------------
  // State of the module
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] mode;             // Mode configuration register
    logic [5:0] filt;             // Filter configuration register
    logic en_prev;                // Enable seen last cycle
    fwf_filt_state_type fsm;      // Time filter state
    logic [WIN_W-1:0] win;        // Current filter window in cycles
    logic [WIN_W-1:0] cnt;        // Window timer
    logic [PER_W-1:0] per;        // Cycles since last validated rise
    logic have_per;               // A period measurement exists
    logic out;                    // Filtered output
    fwf_step_type step;           // Applied hysteresis step
    logic fb;                     // Feedback to hysteresis logic
    logic [31:0] rdata;           // Read data
  } fwf_state_type;

  fwf_state_type state_reg;
  fwf_state_type state_next;

  // ----------------------------------------------------------------
  // Helper signals
  // ----------------------------------------------------------------
  logic [2:0] peak_count;         // Number of tripped comparators
  fwf_step_type auto_step;        // Step from the peak level
  fwf_step_type manual_step;      // Step chosen by software
  logic [PER_W-1:0] per_meas;     // Cycles between the last two validated rises
  logic [WIN_W-1:0] per_win;      // Window derived from the period
  logic [WIN_W-1:0] clamp_win;    // Derived window after clamping
  logic enable;                   // Function enabled
  logic limited;                  // Limited adaptive mode
  logic auto_on;                  // Adaptive algorithm on
  logic fb_from_filter;           // Feedback taken after the filter
  logic both_edges;               // Filter also delays falling edges
  logic win_done;                 // Window timer expired
  logic run;                      // Filter allowed to operate

  // ----------------------------------------------------------------
  // Peak level to hysteresis step
  // ----------------------------------------------------------------
  // Count comparators; each contributes one level
  always_comb begin
    peak_count = 3'h0;
    for (int i = 0; i < 4; i++) begin
      peak_count = peak_count + {2'h0, peak_i[i]};
    end
  end

  // Level n selects step n, so the map cannot decrease
  assign auto_step = fwf_step_type'(peak_count);

  // Manual field saturates at the largest step
  assign manual_step = (state_reg.filt[`FWF_FILT_MANUAL_MSB:`FWF_FILT_MANUAL_LSB] > 3'h4)
                     ? 3'h4
                     : state_reg.filt[`FWF_FILT_MANUAL_MSB:`FWF_FILT_MANUAL_LSB];

  // ----------------------------------------------------------------
  // Configuration decode
  // ----------------------------------------------------------------
  assign enable = state_reg.mode[`FWF_MODE_ENABLE_BIT];
  assign limited = state_reg.mode[`FWF_MODE_LIMITED_BIT];
  assign auto_on = state_reg.mode[`FWF_MODE_AUTO_BIT];
  assign fb_from_filter = state_reg.filt[`FWF_FILT_OPT_LSB];
  assign both_edges = state_reg.filt[`FWF_FILT_OPT_MSB];
  assign run = enable && !diag_i;
  assign win_done = (state_reg.cnt >= state_reg.win);

  // ----------------------------------------------------------------
  // Period to window
  // ----------------------------------------------------------------
  // Period runs rise to rise, so a changed window does not skew it
  assign per_meas = state_reg.per - PER_W'(state_reg.cnt) + PER_W'(1);
  // One thirty-second of the measured period
  assign per_win = per_meas[PER_W-1:`FWF_PERIOD_SHIFT];

  // Keep the window inside its limits
  always_comb begin
    if (per_win < WIN_MIN) begin
      clamp_win = WIN_MIN;
    end else if (per_win > WIN_MAX) begin
      clamp_win = WIN_MAX;
    end else begin
      clamp_win = per_win;
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;

    // Register writes; both configurations apply in either mode
    if (wr_i) begin
      unique case (addr_i)
        `FWF_MODE_CFG_OFS: begin
          state_next.mode = wdata_i[2:0];
        end
        `FWF_FILT_CFG_OFS: begin
          state_next.filt = wdata_i[5:0];
        end
        default: begin
          // Status and unmapped offsets ignore writes
        end
      endcase
    end

    // Register reads answer one cycle later
    state_next.rdata = 32'h0;
    if (rd_i) begin
      unique case (addr_i)
        `FWF_MODE_CFG_OFS: begin
          state_next.rdata = {29'h0, state_reg.mode};
        end
        `FWF_FILT_CFG_OFS: begin
          state_next.rdata = {26'h0, state_reg.filt};
        end
        `FWF_STATUS_OFS: begin
          state_next.rdata[`FWF_STAT_WIN_LSB +: WIN_W] = state_reg.win;
          state_next.rdata[`FWF_STAT_STEP_LSB +: 3] = state_reg.step;
          state_next.rdata[`FWF_STAT_PEAK_LSB +: 4] = peak_i;
          state_next.rdata[`FWF_STAT_OUT_BIT] = state_reg.out;
        end
        default: begin
          // Unmapped offsets read as zero
        end
      endcase
    end

    // Hysteresis step selection
    if (state_reg.filt[`FWF_FILT_FORCE_BIT]) begin
      state_next.step = 3'h0;
    end else if (!auto_on) begin
      state_next.step = manual_step;
    end else if (limited) begin
      // Adaptive, but never below the programmed minimum
      state_next.step = (auto_step > manual_step) ? auto_step : manual_step;
    end else begin
      state_next.step = auto_step;
    end

    // Period counter saturates rather than wrapping
    if (state_reg.per != PER_SAT) begin
      state_next.per = state_reg.per + PER_W'(1);
    end

    // Window timer runs in the waiting states
    if (state_reg.cnt != WIN_MAX) begin
      state_next.cnt = state_reg.cnt + WIN_W'(1);
    end

    state_next.en_prev = enable;

    // Time filter on the squared signal
    unique case (state_reg.fsm)
      FWF_LOW: begin
        state_next.cnt = WIN_W'(1);
        if (sq_i) begin
          state_next.fsm = FWF_RISE_WAIT;
        end
      end
      FWF_RISE_WAIT: begin
        if (!sq_i) begin
          // Short high is a spike and never reaches the output
          state_next.fsm = FWF_LOW;
        end else if (win_done) begin
          state_next.fsm = FWF_HIGH;
          state_next.out = 1'b1;
          // Period counter restarts at the rise that was just validated
          state_next.per = PER_W'(state_reg.cnt);
          state_next.have_per = 1'b1;
          // Only a high lasting the window updates it
          if (limited) begin
            state_next.win = WIN_MIN;
          end else if (state_reg.have_per) begin
            state_next.win = clamp_win;
          end
        end
      end
      FWF_HIGH: begin
        state_next.cnt = WIN_W'(1);
        if (!sq_i) begin
          if (both_edges) begin
            state_next.fsm = FWF_FALL_WAIT;
          end else begin
            state_next.out = 1'b0;
            state_next.fsm = FWF_FALL_WAIT;
          end
        end
      end
      FWF_FALL_WAIT: begin
        if (!state_reg.out) begin
          // Masking: all input transitions ignored
          if (win_done) begin
            state_next.fsm = FWF_LOW;
          end
        end else if (sq_i) begin
          // Both-edge mode: short low is a spike
          state_next.fsm = FWF_HIGH;
        end else if (win_done) begin
          state_next.out = 1'b0;
          state_next.fsm = FWF_LOW;
        end
      end
    endcase

    // Feedback to the hysteresis logic from the chosen point
    state_next.fb = fb_from_filter ? state_next.out : sq_i;

    // Disabled or in diagnosis: no pulses, filter parked
    if (!run) begin
      state_next.fsm = FWF_LOW;
      state_next.out = 1'b0;
      state_next.fb = 1'b0;
    end

    // Rising enable restarts the adaptive window
    if (enable && !state_reg.en_prev) begin
      state_next.win = limited ? WIN_MIN : WIN_MAX;
      state_next.have_per = 1'b0;
      state_next.per = '0;
      state_next.fsm = FWF_LOW;
      state_next.out = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state_reg.mode <= `FWF_MODE_CFG_RESET;
      state_reg.filt <= `FWF_FILT_CFG_RESET;
      state_reg.en_prev <= 1'b0;
      state_reg.fsm <= FWF_LOW;
      state_reg.win <= WIN_MAX;
      state_reg.cnt <= '0;
      state_reg.per <= '0;
      state_reg.have_per <= 1'b0;
      state_reg.out <= 1'b0;
      state_reg.step <= 3'h0;
      state_reg.fb <= 1'b0;
      state_reg.rdata <= 32'h0;
    end else if (ce_i) begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, straight from flip-flops
  // ----------------------------------------------------------------
  assign rdata_o = state_reg.rdata;
  assign filt_o = state_reg.out;
  assign step_o = state_reg.step;
  assign fb_o = state_reg.fb;

endmodule

`default_nettype wire

// >>> design/fwf_regs.svh
`ifndef FWF_REGS_SVH
`define FWF_REGS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define FWF_MODE_CFG_OFS 4'h0
`define FWF_FILT_CFG_OFS 4'h4
`define FWF_STATUS_OFS 4'h8

// ----------------------------------------------------------------
// Mode configuration register fields
// ----------------------------------------------------------------
`define FWF_MODE_ENABLE_BIT 0
`define FWF_MODE_LIMITED_BIT 1
`define FWF_MODE_AUTO_BIT 2
`define FWF_MODE_CFG_RESET 3'h4

// ----------------------------------------------------------------
// Filter configuration register fields
// ----------------------------------------------------------------
`define FWF_FILT_MANUAL_LSB 0
`define FWF_FILT_MANUAL_MSB 2
`define FWF_FILT_OPT_LSB 3
`define FWF_FILT_OPT_MSB 4
`define FWF_FILT_FORCE_BIT 5
`define FWF_FILT_CFG_RESET 6'h00

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define FWF_STAT_WIN_LSB 0
`define FWF_STAT_STEP_LSB 16
`define FWF_STAT_PEAK_LSB 20
`define FWF_STAT_OUT_BIT 24

// ----------------------------------------------------------------
// Timing figures
// ----------------------------------------------------------------
`define FWF_CLK_PERIOD_NS 10
`define FWF_TMIN_NS 4000
`define FWF_TMAX_NS 200000
`define FWF_PERIOD_SHIFT 5

`endif

// >>> design/fwf_pkg.sv
// ----------------------------------------------------------------
// Shared types of the flywheel filter
// ----------------------------------------------------------------
package fwf_pkg;

  // Time filter states
  typedef enum logic [1:0] {
    FWF_LOW,
    FWF_RISE_WAIT,
    FWF_HIGH,
    FWF_FALL_WAIT
  } fwf_filt_state_type;

  // Hysteresis step index, 0 = smallest step
  typedef logic [2:0] fwf_step_type;

  // Thermometer-coded peak level
  typedef logic [3:0] fwf_peak_type;

endpackage

// >>> sim/fwf_filter_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "fwf_regs.svh"
module fwf_filter_sva (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic sq_i,
  input wire fwf_pkg::fwf_peak_type peak_i,
  input wire logic diag_i,
  input wire logic filt_o,
  input wire fwf_pkg::fwf_step_type step_o
);
  import fwf_pkg::*;
  // -----------------
  // Shadow config and run-length counters
  // -----------------
  logic [2:0] mode_reg; // Copy of mode config
  logic [5:0] cfg_reg; // Copy of filter config
  logic [9:0] hi_reg; // Cycles the squared input stayed high
  logic [9:0] low_reg; // Cycles the output stayed low
  // Follows host writes
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      mode_reg <= 3'h4;
      cfg_reg <= 6'h00;
    end else if (wr_i && addr_i == `FWF_MODE_CFG_OFS) begin
      mode_reg <= wdata_i[2:0];
    end else if (wr_i && addr_i == `FWF_FILT_CFG_OFS) begin
      cfg_reg <= wdata_i[5:0];
    end
  end
  // Saturating counters
  always_ff @(posedge ref_clk_i) begin
    hi_reg <= (rst_i || !sq_i) ? 10'h0 : hi_reg + {9'h0, hi_reg != 10'h3ff};
    low_reg <= (rst_i || filt_o) ? 10'h0 : low_reg + {9'h0, low_reg != 10'h3ff};
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  property p_rd_idle; !rd_i |=> rdata_o == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data left standing");
  property p_full; mode_reg[2] && !mode_reg[1] && !cfg_reg[5]
    |=> step_o == 3'($countones($past(peak_i))); endproperty
  a_full: assert property (p_full) else $error("step not from peak level");
  property p_manual; !mode_reg[2] && !cfg_reg[5] |=> step_o ==
    (($past(cfg_reg[2:0]) > 3'h4) ? 3'h4 : $past(cfg_reg[2:0])); endproperty
  a_manual: assert property (p_manual) else $error("manual step ignored");
  property p_force; cfg_reg[5] |=> step_o == 3'h0; endproperty
  a_force: assert property (p_force) else $error("forced step not smallest");
  property p_fall; filt_o && !sq_i && !cfg_reg[4] |=> !filt_o; endproperty
  a_fall: assert property (p_fall) else $error("falling edge delayed");
  property p_rise; $rose(filt_o) |-> hi_reg >= 10'd400; endproperty
  a_rise: assert property (p_rise) else $error("short high passed");
  property p_mask; $rose(filt_o) |-> low_reg >= 10'd400; endproperty
  a_mask: assert property (p_mask) else $error("output rose too soon");
  property p_diag; diag_i |=> !filt_o; endproperty
  a_diag: assert property (p_diag) else $error("pulse during diagnosis");
  property p_off; !mode_reg[0] |=> !filt_o; endproperty
  a_off: assert property (p_off) else $error("pulse while disabled");
endmodule
bind fwf_filter fwf_filter_sva fwf_filter_sva_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .sq_i(sq_i), .peak_i(peak_i), .diag_i(diag_i), .filt_o(filt_o), .step_o(step_o));
`default_nettype wire

// >>> sim/fwf_sensor_model.sv
`timescale 1ns/1ps
`default_nettype none
// Sensor front end: periodic squared signal and peak level
module fwf_sensor_model (
  input wire logic ref_clk_i,
  input wire logic run_i,
  input wire logic [15:0] hi_i,
  input wire logic [15:0] lo_i,
  input wire logic [2:0] level_i,
  output logic sq_o,
  output fwf_pkg::fwf_peak_type peak_o
);
  import fwf_pkg::*;
  logic [15:0] cnt_reg; // Cycles in the current phase
  // One comparator per bit, thermometer coded
  assign peak_o = fwf_peak_type'((5'h01 << level_i) - 5'h01);
  // Low for lo_i cycles, high for hi_i cycles; stands low when stopped
  always_ff @(posedge ref_clk_i) begin
    if (!run_i) begin
      cnt_reg <= 16'h0;
      sq_o <= 1'b0;
    end else if (cnt_reg + 16'h1 >= (sq_o ? hi_i : lo_i)) begin
      cnt_reg <= 16'h0;
      sq_o <= !sq_o;
    end else begin
      cnt_reg <= cnt_reg + 16'h1;
    end
  end
endmodule
`default_nettype wire

// >>> sim/fwf_filter_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "fwf_regs.svh"
module fwf_filter_test;
  import fwf_pkg::*;
  localparam int TMAX = 800; // Shortened maximum window
  localparam int TMIN = 400; // Minimum window
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [3:0] addr_i = 4'h0;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic diag_i = 1'b0;
  logic tb_sq = 1'b0; // Hand-driven squared input
  logic use_model = 1'b0; // Selects the sensor model
  logic run = 1'b0;
  logic [15:0] hi = 16'd900;
  logic [15:0] lo = 16'd13500;
  logic [2:0] level = 3'h0;
  logic m_sq;
  logic sq_i;
  fwf_peak_type peak_i;
  logic [31:0] rdata_o;
  logic filt_o;
  logic fb_o;
  fwf_step_type step_o;
  int n_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  assign sq_i = use_model ? m_sq : tb_sq;
  always #5 ref_clk_i = ~ref_clk_i;
  fwf_filter #(.T_MAX_CYC(TMAX)) fwf_filter_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .ce_i(1'b1), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .sq_i(sq_i), .peak_i(peak_i), .diag_i(diag_i), .filt_o(filt_o),
    .step_o(step_o), .fb_o(fb_o));
  fwf_sensor_model fwf_sensor_model_i (.ref_clk_i(ref_clk_i), .run_i(run), .hi_i(hi),
    .lo_i(lo), .level_i(level), .sq_o(m_sq), .peak_o(peak_i));
  // -----------------
  // Bus cycles and compares
  // -----------------
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t output %b expected %b", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge ref_clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    // Data stand in the cycle after the strobe; taken at its closing edge
    @(posedge ref_clk_i);
    d = rdata_o;
  endtask
  task automatic win(input int exp);
    logic [31:0] d;
    rd(`FWF_STATUS_OFS, d);
    chk32({17'h0, d[14:0]}, 32'(exp));
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  // Collects any high output over n cycles
  task automatic watch(input int n, output logic seen);
    seen = 1'b0;
    repeat (n) begin
      @(posedge ref_clk_i);
      seen = seen | filt_o;
    end
  endtask
  // -----------------
  // Scenarios
  // -----------------
  task automatic t_regs;
    logic [31:0] d;
    rd(`FWF_MODE_CFG_OFS, d);
    chk32(d, 32'h4);
    rd(4'hc, d);
    chk32(d, 32'h0);
    win(TMAX);
    for (int o = 0; o < 4; o++) begin
      wr(`FWF_FILT_CFG_OFS, 32'(o << 3));
      rd(`FWF_FILT_CFG_OFS, d);
      chk32(d, 32'(o << 3));
    end
    wr(`FWF_FILT_CFG_OFS, 32'h0);
  endtask
  task automatic t_edges;
    logic seen;
    wr(`FWF_MODE_CFG_OFS, 32'h5);
    tb_sq <= 1'b1;
    cycles(100);
    chk_bit(fb_o, 1'b1);
    tb_sq <= 1'b0;
    watch(900, seen);
    chk_bit(seen, 1'b0);
    tb_sq <= 1'b1;
    cycles(TMAX + 1);
    chk_bit(filt_o, 1'b0);
    @(posedge ref_clk_i);
    chk_bit(filt_o, 1'b1);
    cycles(50);
    tb_sq <= 1'b0;
    cycles(2);
    chk_bit(filt_o, 1'b0);
    tb_sq <= 1'b1;
    watch(1200, seen);
    chk_bit(seen, 1'b0);
    tb_sq <= 1'b0;
    cycles(1000);
  endtask
  // Both-edge filtering: delayed fall, short low ignored
  task automatic t_both;
    wr(`FWF_FILT_CFG_OFS, 32'h10);
    tb_sq <= 1'b1;
    cycles(TMAX + 10);
    chk_bit(filt_o, 1'b1);
    tb_sq <= 1'b0;
    cycles(100);
    chk_bit(filt_o, 1'b1);
    tb_sq <= 1'b1;
    cycles(100);
    tb_sq <= 1'b0;
    cycles(300);
    chk_bit(filt_o, 1'b1);
    cycles(TMAX);
    chk_bit(filt_o, 1'b0);
    wr(`FWF_FILT_CFG_OFS, 32'h0);
  endtask
  task automatic t_adapt;
    use_model <= 1'b1;
    run <= 1'b1;
    cycles(3 * 14400 + 100);
    win(14400 / 32);
    lo <= 16'd2300;
    cycles(4 * 3200);
    win(TMIN);
    run <= 1'b0;
    wr(`FWF_MODE_CFG_OFS, 32'h4);
    wr(`FWF_MODE_CFG_OFS, 32'h5);
    win(TMAX);
    wr(`FWF_MODE_CFG_OFS, 32'h4);
    wr(`FWF_MODE_CFG_OFS, 32'h7);
    win(TMIN);
  endtask
  task automatic t_step;
    wr(`FWF_MODE_CFG_OFS, 32'h5);
    for (int l = 0; l < 5; l++) begin
      level <= 3'(l);
      cycles(3);
      chk32({29'h0, step_o}, 32'(l));
    end
    wr(`FWF_MODE_CFG_OFS, 32'h1);
    for (int m = 0; m < 8; m++) begin
      wr(`FWF_FILT_CFG_OFS, 32'(m));
      cycles(2);
      chk32({29'h0, step_o}, (m > 4) ? 32'h4 : 32'(m));
    end
    wr(`FWF_FILT_CFG_OFS, 32'h23);
    cycles(2);
    chk32({29'h0, step_o}, 32'h0);
    wr(`FWF_FILT_CFG_OFS, 32'h03);
    cycles(2);
    chk32({29'h0, step_o}, 32'h3);
    level <= 3'h1;
    wr(`FWF_MODE_CFG_OFS, 32'h6);
    cycles(2);
    chk32({29'h0, step_o}, 32'h3);
    wr(`FWF_FILT_CFG_OFS, 32'h0);
    wr(`FWF_MODE_CFG_OFS, 32'h5);
  endtask
  task automatic t_diag;
    logic seen;
    run <= 1'b1;
    diag_i <= 1'b1;
    watch(8000, seen);
    chk_bit(seen, 1'b0);
    diag_i <= 1'b0;
    watch(8000, seen);
    chk_bit(seen, 1'b1);
  endtask
  task automatic tally_and_finish;
    if (n_errors == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Hang guard
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      n_errors++;
      tally_and_finish;
    end
  end
  initial begin
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    t_regs;
    t_edges;
    t_both;
    t_adapt;
    t_step;
    t_diag;
    tally_and_finish;
  end
endmodule
`default_nettype wire
